// File: design/eeprom_array.sv
`timescale 1ns/1ps
module eeprom_array
	import eeprom_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// storage has no reset, as a real array keeps no defined content
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[raddr];
		end
	end
endmodule

// File: design/eeprom_i2c_target.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - master starts a transfer only while the bus is idle
// R2 - data changes while clock high are start or stop conditions
// R3 - start is data falling with clock high; ignore bus before it
// R4 - stop is data rising with clock high; ends current operation
// R5 - master ends every read or write with a stop
// R6 - first byte is slave address; upper four bits default 1010
// R7 - address byte bit zero: one reads, zero writes
// R8 - acknowledge only a matching address, then read or write
// R9 - receiver acknowledges by holding data low on ninth clock
// R10 - counter holds last accessed address plus one
// R11 - counter wraps from highest location to zero
// R12 - read address acknowledged then byte at counter is sent
// R13 - master ends read with no acknowledge then stop
// R14 - random read: dummy write of address, repeated start, read
// R15 - each master acknowledge makes device send another byte
// R16 - sequential reads increment across all address bits
// R17 - after write stop, busy programming; no address acknowledge
// R18 - bytes msb first, data changed only while clock low
// R19 - on master no-acknowledge release data, wait stop or start
module eeprom_i2c_target
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES_P = WRITE_CYCLES,
	parameter logic [2:0] DEV_LO = DEV_LO_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic busy
);
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	state_t st_q;
	kind_t kind_q;
	logic [3:0] cnt_q;
	logic [DATA_W-1:0] shift_q;
	logic [ADDR_W-1:0] addr_q;
	logic rw_q, nack_q, written_q, oe_q, busy_q, sda_o_q;
	logic [BUSY_W-1:0] busy_cnt_q;
	logic [DATA_W-1:0] rdata;

	// two-stage synchronisers, then a history stage for edges
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
		end
	end

	wire scl_hi_w = scl_s_q & scl_p_q;
	wire start_w = scl_hi_w & sda_p_q & ~sda_s_q; // R2 R3
	wire stop_w = scl_hi_w & ~sda_p_q & sda_s_q; // R2 R4
	wire rise_w = scl_s_q & ~scl_p_q;
	wire fall_w = ~scl_s_q & scl_p_q;
	wire byte_done_w = (st_q == ST_RX) && (cnt_q == BITS_PER_BYTE) && fall_w;
	wire match_w = (shift_q[7:1] == {DEV_HI, DEV_LO}); // R6
	wire accept_w = match_w & ~busy_q; // R8 R17
	wire tx_load_w = fall_w && (((st_q == ST_ACK) && (kind_q == K_DEV)
		&& rw_q) || ((st_q == ST_MACK) && !nack_q)); // R12 R15
	wire we_w = byte_done_w && (kind_q == K_DATA);
	// page writes wrap inside the page, not across it
	wire [ADDR_W-1:0] page_next_w = {addr_q[ADDR_W-1:PAGE_W],
		addr_q[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1}};
	wire [BUSY_W-1:0] busy_cnt_d = (stop_w && written_q)
		? BUSY_W'(WRITE_CYCLES_P)
		: (busy_cnt_q != BUSY_RESET) ? busy_cnt_q - BUSY_W'(1) : busy_cnt_q;

	eeprom_array #(.AW(ADDR_W), .DW(DATA_W)) u_array (
		.sys_clk(sys_clk),
		.srst(srst),
		.we(we_w),
		.waddr(addr_q),
		.wdata(shift_q),
		.raddr(addr_q),
		.rdata_q(rdata)
	);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_cnt_q <= BUSY_RESET;
			busy_q <= 1'b0;
			sda_o_q <= 1'b0;
		end else begin
			busy_cnt_q <= busy_cnt_d; // R17
			busy_q <= (busy_cnt_d != BUSY_RESET); // R17
			sda_o_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			kind_q <= K_DEV;
			cnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_q <= ADDR_RESET;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
			written_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (stop_w) begin
			st_q <= ST_IDLE; // R4
			oe_q <= 1'b0;
			written_q <= 1'b0;
		end else if (start_w) begin
			// repeated start lands here too, keeping the counter
			st_q <= ST_RX; // R3 R14
			kind_q <= K_DEV;
			cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				oe_q <= 1'b0; // R3
			end
			ST_RX: begin
				if (rise_w && cnt_q != BITS_PER_BYTE) begin
					shift_q <= {shift_q[6:0], sda_s_q}; // R18
					cnt_q <= cnt_q + 4'h1;
				end else if (byte_done_w) begin
					cnt_q <= 4'h0;
					case (kind_q)
					K_DEV: begin
						if (accept_w) begin
							oe_q <= 1'b1; // R8 R9
							rw_q <= shift_q[0]; // R7
							st_q <= ST_ACK;
						end else begin
							st_q <= ST_IDLE; // R8 R17
						end
					end
					K_WORD: begin
						addr_q <= shift_q;
						oe_q <= 1'b1; // R9
						st_q <= ST_ACK;
					end
					default: begin
						addr_q <= page_next_w; // R10
						written_q <= 1'b1;
						oe_q <= 1'b1; // R9
						st_q <= ST_ACK;
					end
					endcase
				end
			end
			ST_ACK: begin
				if (tx_load_w) begin
					shift_q <= rdata; // R12
					oe_q <= ~rdata[7]; // R18
					addr_q <= addr_q + 8'h01; // R10 R11 R16
					st_q <= ST_TX;
				end else if (fall_w) begin
					oe_q <= 1'b0;
					st_q <= ST_RX;
					kind_q <= (kind_q == K_DEV) ? K_WORD : K_DATA;
				end
			end
			ST_TX: begin
				if (rise_w) begin
					cnt_q <= cnt_q + 4'h1;
				end else if (fall_w) begin
					if (cnt_q == BITS_PER_BYTE) begin
						oe_q <= 1'b0;
						cnt_q <= 4'h0;
						st_q <= ST_MACK;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						oe_q <= ~shift_q[6]; // R18
					end
				end
			end
			ST_MACK: begin
				if (rise_w) begin
					nack_q <= sda_s_q; // R13 R15
				end else if (tx_load_w) begin
					shift_q <= rdata; // R15
					oe_q <= ~rdata[7];
					addr_q <= addr_q + 8'h01; // R11 R16
					st_q <= ST_TX;
				end else if (fall_w) begin
					st_q <= ST_IDLE; // R19
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	assign sda_oe = oe_q;
	assign sda_o = sda_o_q;
	assign busy = busy_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_start;
		start_w && !stop_w |=> st_q == ST_RX && cnt_q == 4'h0 && !oe_q;
	endproperty
	a_start: assert property (p_start) // R3
		else $error("start not taken");

	property p_idle_quiet;
		st_q == ST_IDLE && !start_w |=> st_q == ST_IDLE && !oe_q;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) // R3
		else $error("activity before start");

	property p_stop;
		stop_w |=> st_q == ST_IDLE && !oe_q;
	endproperty
	a_stop: assert property (p_stop) // R4
		else $error("stop did not end operation");

	property p_reject;
		byte_done_w && kind_q == K_DEV && !start_w && !stop_w
			&& !(match_w && !busy_q) |=> st_q == ST_IDLE && !oe_q;
	endproperty
	a_reject: assert property (p_reject) // R8 R17
		else $error("foreign or busy address acknowledged");

	property p_ack_low;
		st_q == ST_ACK |-> oe_q && !sda_o_q;
	endproperty
	a_ack_low: assert property (p_ack_low) // R9
		else $error("ack not driven low");

	property p_incr;
		tx_load_w && !start_w && !stop_w
			|=> addr_q == $past(addr_q) + 8'h01 && st_q == ST_TX;
	endproperty
	a_incr: assert property (p_incr) // R10 R11 R16
		else $error("counter not incremented");

	property p_first_bit;
		tx_load_w && !start_w && !stop_w |=> oe_q == ~$past(rdata[7]);
	endproperty
	a_first_bit: assert property (p_first_bit) // R12 R15
		else $error("wrong first data bit");

	property p_busy;
		stop_w && written_q |=> busy_q [*8];
	endproperty
	a_busy: assert property (p_busy) // R17
		else $error("write cycle not busy");

	property p_scl_low;
		$changed(oe_q) |-> $past(!scl_s_q || start_w || stop_w);
	endproperty
	a_scl_low: assert property (p_scl_low) // R18 R2
		else $error("data changed with clock high");

	property p_nack;
		st_q == ST_MACK && fall_w && nack_q && !start_w && !stop_w
			|=> st_q == ST_IDLE && !oe_q;
	endproperty
	a_nack: assert property (p_nack) // R19 R13
		else $error("no release after master nack");
endmodule

// File: design/eeprom_pkg.sv
package eeprom_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 4;
	localparam logic [3:0] DEV_HI = 4'hA;
	localparam logic [2:0] DEV_LO_DEFAULT = 3'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int CLK_HZ = 125_000_000;
	localparam int WRITE_CYCLE_MS = 5;
	// longest time: round down
	localparam int WRITE_CYCLES = (CLK_HZ / 1000) * WRITE_CYCLE_MS;
	localparam int BUSY_W = 20;
	localparam logic [BUSY_W-1:0] BUSY_RESET = 20'h00000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_MACK = 3'b100
	} state_t;

	typedef enum logic [1:0] {
		K_DEV = 2'b00,
		K_WORD = 2'b01,
		K_DATA = 2'b10
	} kind_t;
endpackage

// File: verification/eeprom_i2c_target_bench.sv
`timescale 1ns/1ps
module eeprom_i2c_target_bench;
	import eeprom_pkg::*;
	// long enough to cover a whole address frame
	localparam int WC = 400;
	logic sys_clk, srst, scl, sda_m, sda, sda_o, sda_oe, busy, ack;
	logic [7:0] mem [256];
	logic [7:0] d, nxt;
	logic [7:0] bad [3] = '{8'hB1, 8'hA3, 8'h21};
	int mismatches, check_count;
	int seed = 32'h2ED7;
	// open drain with pull-up
	assign sda = sda_m & (sda_oe ? sda_o : 1'b1);
	eeprom_i2c_target #(.WRITE_CYCLES_P(WC), .DEV_LO(3'h0)) dut_u (
		.sys_clk(sys_clk), .srst(srst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
	i2c_master_model m_u (.sys_clk(sys_clk), .sda(sda), .scl(scl),
		.sda_m(sda_m));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// page writes roll over inside the low four address bits
	function automatic logic [7:0] page_at(input logic [7:0] base,
		input int i);
		return {base[7:4], base[3:0] + 4'(i)};
	endfunction
	task automatic wpage(input logic [7:0] base, input int n);
		m_u.start();
		m_u.wr(8'hA0, ack);
		chk(8'(ack), 8'h01);
		m_u.wr(base, ack);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			mem[page_at(base, i)] = d;
			m_u.wr(d, ack);
		end
		m_u.stop();
		repeat (8) @(negedge sys_clk);
		chk(8'(busy), 8'h01);
		m_u.start();
		m_u.wr(8'hA1, ack);
		chk(8'(ack), 8'h00);
		m_u.stop();
		repeat (WC) @(negedge sys_clk);
		chk(8'(busy), 8'h00);
	endtask
	task automatic seqrd(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++) begin
			m_u.rd(i < n - 1, d);
			chk(d, mem[8'(base + i)]);
		end
		// a wrongly sent next bit would show a few clocks after the fall
		repeat (2) @(negedge sys_clk);
		chk(8'(sda_oe), 8'h00);
		m_u.stop();
		nxt = 8'(base + n);
	endtask
	task automatic rread(input logic [7:0] base, input int n);
		m_u.start();
		m_u.wr(8'hA0, ack);
		m_u.wr(base, ack);
		chk(8'(ack), 8'h01);
		m_u.start();
		m_u.wr(8'hA1, ack);
		chk(8'(ack), 8'h01);
		seqrd(base, n);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#400000;
		mismatches++;
		end_sim();
	end
	initial begin
		srst = 1'b1;
		repeat (6) @(negedge sys_clk);
		srst = 1'b0;
		repeat (6) @(negedge sys_clk);
		chk(8'({sda_oe, busy, sda_o}), 8'h00);
		wpage(8'hF0, 16);
		wpage(8'h00, 16);
		wpage(8'h10, 2);
		$display("writes done");
		// crosses the top of the array
		rread(8'hF8, 24);
		m_u.start();
		m_u.wr(8'hA1, ack);
		chk(8'(ack), 8'h01);
		seqrd(nxt, 2);
		$display("reads done");
		foreach (bad[i]) begin
			m_u.start();
			m_u.wr(bad[i], ack);
			chk(8'(ack), 8'h00);
			m_u.stop();
		end
		// own address clocked in with no start
		m_u.wr(8'hA1, ack);
		chk(8'(ack), 8'h00);
		m_u.stop();
		$display("refusals done");
		end_sim();
	end
endmodule

// File: verification/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// quarter of a 64 ns bus clock period
	task automatic q;
		repeat (2) @(negedge sys_clk);
	endtask
	// data moves only with clock low, msb first
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
		q();
	endtask
	// also serves as repeated start
	task automatic start;
		sda_m = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop;
		sda_m = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_m = 1'b1;
		q();
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, r);
	endtask
endmodule
